/* mpa_pkg.sv */
/*
 * Package for the meter pulse input accumulator: register map, field
 * layout, reset values and timing constants.
 * Assumes a 50 MHz clock and a 32-bit APB register bus.
 */
package mpa_pkg;
	// ==========================================================
	// Channel count and widths
	localparam int NCH          = 12;
	localparam int DEB_W        = 8;   // Debounce steps of 10 ms, 1..255
	localparam int CNT_W        = 16;  // Temporary pulse counter width
	localparam int IVL_W        = 16;  // Interval, in 5 ms samples
	localparam int CHIDX_W      = 4;

	// ==========================================================
	// Timing
	localparam int CLK_HZ       = 50_000_000;
	localparam int SAMPLE_US    = 5000;
	localparam int SAMPLE_CYC   = CLK_HZ / 1_000_000 * SAMPLE_US;
	localparam int STEP_MS      = 10;
	localparam int STEP_SAMPLES = STEP_MS * 1000 / SAMPLE_US;
	localparam int HANDOVER_MS  = 1000;
	localparam int HANDOVER_SMP = HANDOVER_MS * 1000 / SAMPLE_US;
	localparam int TICK_W       = 18;
	localparam int HO_W         = 8;

	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] OFS_EDGE   = 12'h000; // Edge select, bit n = channel n+1
	localparam logic [11:0] OFS_GATE   = 12'h004; // Pulse accept gate, 1 = start
	localparam logic [11:0] OFS_LEVEL  = 12'h008; // Debounced levels (RO)
	localparam logic [11:0] OFS_TARIFF = 12'h00c; // Bit0 enable, bit1 current tariff (RO)
	localparam logic [11:0] OFS_HSEQ   = 12'h010; // Handover sequence number (RO)
	localparam logic [11:0] OFS_DEB0   = 12'h040; // Debounce per channel, +4 each
	localparam logic [11:0] OFS_HCNT0  = 12'h080; // Handed-over count, +4 each (RO)
	localparam logic [11:0] OFS_IVL0   = 12'h0c0; // Last pulse interval, +4 each (RO)
	localparam logic [11:0] OFS_ENT10  = 12'h100; // First tariff pulse total (RO)
	localparam logic [11:0] OFS_ENT20  = 12'h140; // Second tariff pulse total (RO)

	// ==========================================================
	// Reset values
	localparam logic [NCH-1:0]   RST_EDGE = '1;
	localparam logic [NCH-1:0]   RST_GATE = '1;
	localparam logic [DEB_W-1:0] RST_DEB  = 8'h01;
	localparam int TARIFF_CH = NCH - 1;      // Input 12 selects the tariff
	localparam int TEN_BIT   = 0;
	localparam int TCUR_BIT  = 1;
endpackage : mpa_pkg

/* mpa_top.sv */
/*
 * Meter pulse input accumulator: samples, debounces and counts pulses of
 * twelve meter inputs, measures pulse intervals and hands over counts.
 * Assumes inputs synchronous to clk and an APB master on the bus side.
 */
// Functional notes
// - Every input is sampled once every 5 ms by one common tick.
// - Each input has a debounce time of 10 ms to 2.55 s in 10 ms steps.
// - Each of twelve channels has its own debounce and edge setting.
// - With edge setting 1 only a debounced low-to-high change is a pulse.
// - With edge setting 0 only a debounced high-to-low change is a pulse.
// - A new level is accepted only after being stable for the debounce time.
// - The status shows only debounced levels, never raw samples.
// - A stopped channel does not count pulses.
// - The gate does not change the reported debounced level.
// - Each accepted pulse increments that channel's temporary counter.
// - Every 1 to 2 seconds each temporary count is handed over and totalled.
// - Input n feeds channel n only.
// - Each channel measures the time between consecutive accepted pulses.
// - The debounced level of input 12 can pick one of two tariffs.
module mpa_top
	import mpa_pkg::*;
#(
	parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   resetn,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Meter side
	input  wire logic [mpa_pkg::NCH-1:0] meter_pulse_inputs,
	// Handover strobe toward energy conversion
	output logic                        handover_stb,
	output logic                        first_tariff,
	output logic                        second_tariff
);
	import mpa_pkg::*;

	// ==========================================================
	// State
	// The stability counter is two bits wider than the debounce setting,
	// since every 10 ms step of debounce is two sample ticks.
	logic [TICK_W-1:0]  tick_r, tick_nxt;
	logic               smp;
	logic [HO_W-1:0]    ho_r, ho_nxt;
	logic               ho;
	logic [NCH-1:0]     edge_r, edge_nxt, gate_r, gate_nxt, lvl_r, lvl_nxt;
	logic               ten_r, ten_nxt, tcur_r, tcur_nxt;
	logic [31:0]        hseq_r, hseq_nxt;
	logic [DEB_W-1:0]   deb_r [NCH], deb_nxt [NCH];
	logic [DEB_W+1:0]   stab_r [NCH], stab_nxt [NCH];
	logic [CNT_W-1:0]   cnt_r [NCH], cnt_nxt [NCH], hcnt_r [NCH], hcnt_nxt [NCH];
	logic [IVL_W-1:0]   run_r [NCH], run_nxt [NCH], ivl_r [NCH], ivl_nxt [NCH];
	logic [NCH-1:0]     seen_r, seen_nxt;
	logic [31:0]        ftot_r [NCH], ftot_nxt [NCH], stot_r [NCH], stot_nxt [NCH];
	logic [31:0]        rd_nxt, prdata_r;
	logic [NCH-1:0]     pulse;
	logic               wr, rd;

	// Index of a per-channel block register, or NCH when out of range
	// Misaligned and out-of-block addresses both give NCH, so every
	// caller needs only one bound test.
	function automatic logic [CHIDX_W:0] ch_of(input logic [11:0] a, input logic [11:0] base);
		logic [11:0] d;
		d = a - base;
		if (a >= base && d[11:2] < 10'(NCH) && d[1:0] == 2'b00)
			ch_of = (CHIDX_W+1)'(d[11:2]);
		else
			ch_of = (CHIDX_W+1)'(NCH);
	endfunction

	// ==========================================================
	// Bus handshake and outputs
	// Zero wait states: every register answers from flops at once.
	assign wr      = psel & penable & pwrite;
	assign rd      = psel & ~penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign prdata  = prdata_r;
	assign smp     = (tick_r == TICK_W'(SAMPLE_CYCLES - 1));
	assign ho      = smp & (ho_r == HO_W'(HANDOVER_SMP - 1));
	assign handover_stb  = ho;
	assign first_tariff  = ~tcur_r;
	assign second_tariff = tcur_r;

	// ==========================================================
	// Sample tick and handover period
	// A 1 s handover sits inside the allowed 1 to 2 s window and keeps
	// the totals in step with whole seconds.
	always_comb begin
		tick_nxt = smp ? '0 : tick_r + 1'b1;
		ho_nxt   = ho_r;
		if (smp)
			ho_nxt = ho ? '0 : ho_r + 1'b1;
	end

	// ==========================================================
	// Per-channel debounce, edge, gate, counting and interval
	// Handover happens on a sample tick, so a pulse of that tick goes to
	// the fresh count instead of being cleared away.
	always_comb begin
		lvl_nxt  = lvl_r;
		seen_nxt = seen_r;
		pulse    = '0;
		hseq_nxt = ho ? hseq_r + 1'b1 : hseq_r;
		tcur_nxt = ten_r & lvl_r[TARIFF_CH];
		for (int i = 0; i < NCH; i++) begin
			stab_nxt[i] = stab_r[i];
			cnt_nxt[i]  = cnt_r[i];
			hcnt_nxt[i] = hcnt_r[i];
			run_nxt[i]  = run_r[i];
			ivl_nxt[i]  = ivl_r[i];
			ftot_nxt[i] = ftot_r[i];
			stot_nxt[i] = stot_r[i];
			if (smp) begin
				// Stability counts ticks that disagree with the accepted level;
				// one agreeing sample starts the wait again.
				// Raw sample of input i feeds channel i only
				if (meter_pulse_inputs[i] == lvl_r[i]) begin
					stab_nxt[i] = '0;
				end else if (stab_r[i] + 1'b1 >= (DEB_W+2)'(deb_r[i]) * (DEB_W+2)'(STEP_SAMPLES)) begin
					stab_nxt[i] = '0;
					lvl_nxt[i]  = meter_pulse_inputs[i];
					// A stopped channel still tracks its level; only the pulse is dropped
					// Edge polarity from the channel's own setting
					pulse[i] = (meter_pulse_inputs[i] == edge_r[i]) & gate_r[i];
				end else begin
					stab_nxt[i] = stab_r[i] + 1'b1;
				end
				if (run_r[i] != '1)
					run_nxt[i] = run_r[i] + 1'b1;  // Saturates on long gaps
				if (pulse[i]) begin
					// A gap too long to count reads as the top value, never wraps
					if (seen_r[i])
						ivl_nxt[i] = (run_r[i] == '1) ? run_r[i] : run_r[i] + 1'b1;
					run_nxt[i]  = '0;
					seen_nxt[i] = 1'b1;
				end
				if (ho) begin
					hcnt_nxt[i] = cnt_r[i];
					cnt_nxt[i]  = CNT_W'(pulse[i]);
					// The whole period goes to the tariff in force at handover;
					// a tariff change inside the period is not split.
					if (tcur_r)
						stot_nxt[i] = stot_r[i] + 32'(cnt_r[i]);
					else
						ftot_nxt[i] = ftot_r[i] + 32'(cnt_r[i]);
				end else if (pulse[i]) begin
					cnt_nxt[i] = cnt_r[i] + 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Register writes
	// Writes land at the access edge; read-only and unmapped addresses
	// fall to the default branch and change nothing.
	always_comb begin
		logic [CHIDX_W:0] c;
		c        = ch_of(paddr, OFS_DEB0);
		edge_nxt = edge_r;
		gate_nxt = gate_r;
		ten_nxt  = ten_r;
		for (int i = 0; i < NCH; i++)
			deb_nxt[i] = deb_r[i];
		if (wr) begin
			unique case (paddr)
				OFS_EDGE:   edge_nxt = pwdata[NCH-1:0];
				OFS_GATE:   gate_nxt = pwdata[NCH-1:0];
				OFS_TARIFF: ten_nxt  = pwdata[TEN_BIT];
				default: begin
					// Zero would mean no debounce; keep the 10 ms floor
					if (c < (CHIDX_W+1)'(NCH) && pwdata[DEB_W-1:0] != '0)
						deb_nxt[c[CHIDX_W-1:0]] = pwdata[DEB_W-1:0];
				end
			endcase
		end
	end

	// ==========================================================
	// Read mux, captured in the setup cycle
	// Taking the word at setup lets it stand through the access phase
	// with zero wait states; it then holds until the next read setup.
	always_comb begin
		logic [CHIDX_W:0] c;
		c      = '0;
		rd_nxt = prdata_r;
		if (rd) begin
			rd_nxt = '0;
			unique case (paddr)
				OFS_EDGE:   rd_nxt = 32'(edge_r);
				OFS_GATE:   rd_nxt = 32'(gate_r);
				OFS_LEVEL:  rd_nxt = 32'(lvl_r);
				OFS_TARIFF: rd_nxt = {30'h0, tcur_r, ten_r};
				OFS_HSEQ:   rd_nxt = hseq_r;
				default: begin
					c = ch_of(paddr, OFS_DEB0);
					if (c < (CHIDX_W+1)'(NCH)) rd_nxt = 32'(deb_r[c[CHIDX_W-1:0]]);
					c = ch_of(paddr, OFS_HCNT0);
					if (c < (CHIDX_W+1)'(NCH)) rd_nxt = 32'(hcnt_r[c[CHIDX_W-1:0]]);
					c = ch_of(paddr, OFS_IVL0);
					if (c < (CHIDX_W+1)'(NCH)) rd_nxt = 32'(ivl_r[c[CHIDX_W-1:0]]);
					c = ch_of(paddr, OFS_ENT10);
					if (c < (CHIDX_W+1)'(NCH)) rd_nxt = ftot_r[c[CHIDX_W-1:0]];
					c = ch_of(paddr, OFS_ENT20);
					if (c < (CHIDX_W+1)'(NCH)) rd_nxt = stot_r[c[CHIDX_W-1:0]];
				end
			endcase
		end
	end

	// ==========================================================
	// Registers: sample tick and handover period
	// Both counters restart together, so the first handover falls one
	// full handover period after reset.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tick_r <= '0;
			ho_r   <= '0;
		end else begin
			tick_r <= tick_nxt;
			ho_r   <= ho_nxt;
		end
	end

	// ==========================================================
	// Registers: software settings
	// Reset leaves every channel counting rising edges with the shortest
	// debounce, so the block counts before software configures it.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			edge_r <= RST_EDGE;
			gate_r <= RST_GATE;
			ten_r  <= 1'b0;
			for (int i = 0; i < NCH; i++)
				deb_r[i] <= RST_DEB;
		end else begin
			edge_r <= edge_nxt;
			gate_r <= gate_nxt;
			ten_r  <= ten_nxt;
			for (int i = 0; i < NCH; i++)
				deb_r[i] <= deb_nxt[i];
		end
	end

	// ==========================================================
	// Registers: levels, counters, intervals and totals
	// Levels start low, matching an open meter contact, so reset
	// itself never produces a pulse.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lvl_r  <= '0;
			seen_r <= '0;
			tcur_r <= 1'b0;
			hseq_r <= '0;
			for (int i = 0; i < NCH; i++) begin
				stab_r[i] <= '0;
				cnt_r[i]  <= '0;
				hcnt_r[i] <= '0;
				run_r[i]  <= '0;
				ivl_r[i]  <= '0;
				ftot_r[i] <= '0;
				stot_r[i] <= '0;
			end
		end else begin
			lvl_r  <= lvl_nxt;
			seen_r <= seen_nxt;
			tcur_r <= tcur_nxt;
			hseq_r <= hseq_nxt;
			for (int i = 0; i < NCH; i++) begin
				stab_r[i] <= stab_nxt[i];
				cnt_r[i]  <= cnt_nxt[i];
				hcnt_r[i] <= hcnt_nxt[i];
				run_r[i]  <= run_nxt[i];
				ivl_r[i]  <= ivl_nxt[i];
				ftot_r[i] <= ftot_nxt[i];
				stot_r[i] <= stot_nxt[i];
			end
		end
	end

	// ==========================================================
	// Registers: read data
	// Holds between reads, so a late look at prdata still sees the word.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata_r <= '0;
		end else begin
			prdata_r <= rd_nxt;
		end
	end
endmodule // mpa_top

/* mpa_chk.sv */
/* Port checker for the meter pulse input accumulator.
   Assumes it is bound to mpa_top and gets the same sample period. */
// ==========================================
// Checker
module mpa_chk
	import mpa_pkg::*;
#(parameter int SAMPLE_CYCLES = 10) (
	// Clock and reset
	input wire logic                    clk,
	input wire logic                    resetn,
	// APB
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [11:0]             paddr,
	input wire logic [31:0]             pwdata,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	// Meter side and outputs
	input wire logic [mpa_pkg::NCH-1:0] meter_pulse_inputs,
	input wire logic                    handover_stb,
	input wire logic                    first_tariff,
	input wire logic                    second_tariff
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HP = 200 * SAMPLE_CYCLES;
	int gap_r;
	int gap_nxt;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Cycles since the last handover; small slack covers the first one
	always_comb gap_nxt = handover_stb ? 0 : gap_r + 1;
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) gap_r <= 0;
		else gap_r <= gap_nxt;
	property p_hgap; handover_stb |-> gap_r >= HP - 3 && gap_r <= HP + 1; endproperty
	a_hgap: assert property (p_hgap) else $error("handover spacing wrong");
	property p_stbsep; handover_stb |=> !handover_stb [*8]; endproperty
	a_stbsep: assert property (p_stbsep) else $error("handover strobe too long");
	property p_trf; first_tariff != second_tariff; endproperty
	a_trf: assert property (p_trf) else $error("tariff outputs not exclusive");
	property p_t2stab; $changed(second_tariff) |=> $stable(second_tariff) [*8]; endproperty
	a_t2stab: assert property (p_t2stab) else $error("tariff follows an undebounced level");
	property p_rdy; pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready low");
	property p_err; !pslverr; endproperty
	a_err: assert property (p_err) else $error("pslverr raised");
	property p_rdchg; $changed(prdata) |-> $past(psel && !penable && !pwrite); endproperty
	a_rdchg: assert property (p_rdchg) else $error("prdata changed outside a read");
	property p_rdzero; psel && penable && !pwrite && paddr == 12'h020 |-> prdata == 32'h0; endproperty
	a_rdzero: assert property (p_rdzero) else $error("unmapped read not zero");
	c_ho: cover property (handover_stb);
	c_rd: cover property (psel && penable && !pwrite);
	c_in: cover property ($changed(meter_pulse_inputs));
endmodule // mpa_chk

bind mpa_top mpa_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) mpa_chk_i (.clk(clk), .resetn(resetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .meter_pulse_inputs(meter_pulse_inputs), .handover_stb(handover_stb),
	.first_tariff(first_tariff), .second_tariff(second_tariff));

/* mpa_meter.sv */
/* Model of twelve meter contacts that bounce after each change.
   Assumes one-cycle toggle commands synchronous to clk. */
// ==========================================
// Meter contacts
module mpa_meter (
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// Toggle commands and contact levels
	input wire logic [11:0] fire,
	output logic     [11:0] line
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] st_r, st_nxt, lm_r, lm_nxt;
	logic [1:0]  bc_r, bc_nxt;
	// A toggle is followed by three cycles of bounce, shorter than a tick
	always_comb begin
		st_nxt = st_r ^ fire;
		lm_nxt = (fire != 12'h000) ? fire : lm_r;
		bc_nxt = (fire != 12'h000) ? 2'h3 : bc_r - {1'b0, bc_r != 2'h0};
	end
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) {st_r, lm_r, bc_r} <= '0;
		else {st_r, lm_r, bc_r} <= {st_nxt, lm_nxt, bc_nxt};
	// Odd bounce counts show the old level
	assign line = st_r ^ (bc_r[0] ? lm_r : 12'h000);
endmodule // mpa_meter

/* mpa_top_tb_top.sv */
/* Self-checking bench for the accumulator with bouncing meter contacts.
   Assumes mpa_pkg and a shortened sample period. */
// ==========================================
// Bench top
module mpa_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import mpa_pkg::*;
	localparam int SC = 10;
	logic           clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0]    paddr = '0, fire = '0, m, edg, gate, lvl = '0;
	logic [NCH-1:0] line;
	logic [31:0]    pwdata = '0, prdata, s = 32'd44, q[$];
	logic           pready, pslverr, hstb, trf_first, trf_second;
	int             mismatches = 0, checked = 0, exp_c[NCH] = '{default: 0};
	int             lp[NCH] = '{default: -1}, pp[NCH] = '{default: -1};
	always #10 clk = ~clk;
	mpa_top #(.SAMPLE_CYCLES(SC)) mpa_top_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.meter_pulse_inputs(line), .handover_stb(hstb), .first_tariff(trf_first), .second_tariff(trf_second));
	mpa_meter mpa_meter_i (.clk(clk), .resetn(resetn), .fire(fire), .line(line));
	function automatic logic [31:0] xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(string n, logic [31:0] v, logic [31:0] e);
		checked++;
		if (v !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, v);
		end
	endtask
	task automatic summarize();
		$display("Checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic give_up();
		mismatches++;
		summarize();
	endtask
	// APB transfer; a read notes its expected word first
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		int k;
		if (!w) q.push_back(d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, w ? d : 32'h0};
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 20) give_up();
		{psel, penable} <= 2'b00;
	endtask
	task automatic wait_ho();
		int k;
		for (k = 0; k < 250 * SC; k++) begin
			@(posedge clk);
			if (hstb === 1'b1) break;
		end
		if (k == 250 * SC) give_up();
	endtask
	task automatic pulse(logic [11:0] t);
		@(posedge clk);
		fire <= t;
		@(posedge clk);
		fire <= 12'h000;
	endtask
	// Read data is compared at the edge that completes each read
	always @(posedge clk)
		if (psel && penable && !pwrite && pready === 1'b1) chk("prdata", prdata, q.pop_front());
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		edg = 12'(xs());
		gate = 12'(xs());
		apb(1, OFS_EDGE, {20'h0, edg});
		apb(1, OFS_GATE, {20'h0, gate});
		apb(1, OFS_DEB0, 32'h0);
		apb(1, OFS_DEB0 + 12'h004, 32'hff);
		apb(1, OFS_TARIFF, 32'h1);
		apb(0, OFS_DEB0, 32'h1);
		apb(0, OFS_DEB0 + 12'h004, 32'hff);
		apb(0, 12'h020, 32'h0);
		wait_ho();
		// Each round: a glitch too short to accept, then a real change
		// Rounds of 200 cycles keep the tick phase fixed, so intervals are exact
		for (int r = 0; r < 8; r++) begin
			m = 12'(xs());
			pulse(m);
			repeat (6) @(posedge clk);
			pulse(m);
			repeat (40) @(posedge clk);
			pulse(m);
			// Channel 2 has the longest debounce and never settles
			for (int n = 0; n < NCH; n++)
				if (m[n] && n != 1) begin
					lvl[n] = ~lvl[n];
					if (lvl[n] == edg[n] && gate[n]) begin
						exp_c[n]++;
						pp[n] = lp[n];
						lp[n] = r;
					end
				end
			repeat (148) @(posedge clk);
		end
		wait_ho();
		for (int n = 0; n < NCH; n++) begin
			apb(0, OFS_HCNT0 + 12'(4 * n), exp_c[n]);
			apb(0, OFS_IVL0 + 12'(4 * n), (pp[n] < 0) ? 0 : 200 / SC * (lp[n] - pp[n]));
			apb(0, OFS_ENT10 + 12'(4 * n), lvl[11] ? 0 : exp_c[n]);
			apb(0, OFS_ENT20 + 12'(4 * n), lvl[11] ? exp_c[n] : 0);
		end
		apb(0, OFS_LEVEL, {20'h0, lvl});
		apb(0, OFS_HSEQ, 32'h2);
		@(negedge clk);
		chk("second_tariff", trf_second, lvl[11]);
		chk("first_tariff", trf_first, !lvl[11]);
		repeat (2) @(posedge clk);
		summarize();
	end
endmodule // mpa_top_tb_top
